//--- verilog/owd_pkg.sv
// Constants for the operating watchdog: register map, field positions,
// reset values and counter figures.
// Assumes a 16-bit address, 8-bit data register port on the block clock.
package owd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] ADDR_SERVICE = 16'hffff;
   localparam logic [15:0] ADDR_CONFIG = 16'h001f;
   localparam logic [15:0] ADDR_CAUSE = 16'h001e;
   localparam logic [15:0] ADDR_COUNT = 16'h001d;
   localparam int CFG_DISABLE_BIT = 0;
   localparam int CFG_STOP_ALLOW_BIT = 1;
   localparam int CFG_RATE_BIT = 2;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int CAUSE_WATCHDOG_BIT = 1;
   localparam int PRESCALER_W = 12;
   localparam int WATCHDOG_W = 6;
   localparam int CHAIN_W = PRESCALER_W + WATCHDOG_W;
   localparam int SERVICE_CLEAR_LSB = 4;
   localparam int TIMEOUT_LONG = 262128;
   localparam int TIMEOUT_SHORT = 8176;
   localparam int POR_CYCLES = 4096;
   localparam int PULL_CYCLES = 32;
   localparam logic [7:0] REF_DIV_RESET = 8'h01;
   typedef enum logic [1:0] {MODE_RUN, MODE_STOP, MODE_PULL} owd_mode_e;
endpackage : owd_pkg

//--- verilog/owd_watchdog.sv
// Operating watchdog: prescaler plus watchdog counter, service register,
// reset pulse on the reset pin and reset-cause flag.
// Assumes all inputs synchronous to clock; reference rate is clock / ref_div.
//
// Function
// - 6-bit counter behind 12-bit reference prescaler
// - Overflow after 262128 or 8176 reference cycles
// - Rate select clears on reset, long period
// - Service write clears counter, prescaler stages 12-5
// - Service read returns vector low byte
// - Overflow pulls reset pin 32 cycles, sets cause
// - Monitor mode plus test voltage disables
// - Break state plus test voltage on reset pin disables
// - Stop instruction clears prescaler
// - Power-on clears prescaler after 4096 cycles
// - Internal reset clears prescaler and counter
// - Reset vector fetch clears prescaler
// - Disable bit set stops all watchdog resets
// - Counting continues in wait mode
// - Stop mode freezes counter, clears prescaler
// - Stop honoured only when stop-allow set
// - No interrupt request, only reset
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module owd_watchdog
   import owd_pkg::*;
#(
   parameter logic [7:0] REF_DIV = REF_DIV_RESET,
   parameter int TIMEOUT_LONG_CYCLES = TIMEOUT_LONG,
   parameter int TIMEOUT_SHORT_CYCLES = TIMEOUT_SHORT,
   parameter logic [7:0] RESET_VECTOR_LOW = 8'h00 // Arbitrary value
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic internal_reset,
   input wire logic vector_fetch,
   input wire logic stop_request,
   input wire logic stop_wake,
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic test_voltage_reset_pin,
   input wire logic test_voltage_irq_pin,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic watchdog_reset,
   output logic stop_mode
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] div_count;
   logic ref_tick;
   logic [PRESCALER_W-1:0] prescaler;
   logic [PRESCALER_W-1:0] next_prescaler;
   logic [WATCHDOG_W-1:0] wd_count;
   logic [WATCHDOG_W-1:0] next_wd_count;
   logic [7:0] cfg;
   logic cause_flag;
   logic [12:0] por_count;
   logic por_done;
   logic [4:0] pull_count;
   owd_mode_e mode;
   owd_mode_e next_mode;
   logic [DATA_W-1:0] read_value;

   wire svc_write = wr && (addr == ADDR_SERVICE);
   wire cfg_write = wr && (addr == ADDR_CONFIG);
   wire cause_read = rd && (addr == ADDR_CAUSE);
   wire [CHAIN_W-1:0] chain = {wd_count, prescaler};
   wire rate_short = cfg[CFG_RATE_BIT];
   wire [CHAIN_W-1:0] limit_long = CHAIN_W'(TIMEOUT_LONG_CYCLES - 1);
   wire [CHAIN_W-1:0] limit_short = CHAIN_W'(TIMEOUT_SHORT_CYCLES - 1);
   wire [CHAIN_W-1:0] limit = rate_short ? limit_short : limit_long;
   wire monitor_off = monitor_mode &&
      (test_voltage_reset_pin || test_voltage_irq_pin);
   wire break_off = break_state && test_voltage_reset_pin;
   wire active = !cfg[CFG_DISABLE_BIT] && !monitor_off && !break_off;
   // Wait mode has no input here: counting is never gated by it
   wire count_enable = ref_tick && active && (mode == MODE_RUN);
   wire overflow = count_enable && (chain == limit);
   wire stop_enter = stop_request && cfg[CFG_STOP_ALLOW_BIT] &&
      (mode == MODE_RUN);
   wire por_clear = ref_tick && !por_done &&
      (por_count == 13'(POR_CYCLES - 1));
   wire pull_done = ref_tick && (pull_count == 5'(PULL_CYCLES - 1));
   wire [CHAIN_W-1:0] chain_inc = chain + 18'h00001;

   ////////////////////////////////////////////////////////////////////////
   // Reference rate enable
   always_ff @(posedge clock)
   begin
      if (reset || div_count == REF_DIV - 8'h01)
         div_count <= 8'h00;
      else
         div_count <= div_count + 8'h01;
   end

   assign ref_tick = (div_count == REF_DIV - 8'h01);

   ////////////////////////////////////////////////////////////////////////
   // Counter chain
   always_comb
   begin
      next_prescaler = prescaler;
      next_wd_count = wd_count;
      if (internal_reset || mode == MODE_PULL || overflow)
      begin
         next_prescaler = '0;
         next_wd_count = '0;
      end
      else
      begin
         if (count_enable)
         begin
            next_prescaler = chain_inc[PRESCALER_W-1:0];
            next_wd_count = chain_inc[CHAIN_W-1:PRESCALER_W];
         end
         if (svc_write)
         begin
            next_prescaler[PRESCALER_W-1:SERVICE_CLEAR_LSB] = '0;
            next_wd_count = '0;
         end
         if (stop_enter) next_prescaler = '0;
         if (mode == MODE_STOP) next_prescaler = '0;
         if (vector_fetch) next_prescaler = '0;
         if (por_clear) next_prescaler = '0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         prescaler <= '0;
         wd_count <= '0;
      end
      else
      begin
         prescaler <= next_prescaler;
         wd_count <= next_wd_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode: run, stop (count enable gated off, prescaler held clear), pulling the reset pin
   always_comb
   begin
      next_mode = mode;
      case (mode)
         MODE_RUN:
         begin
            if (overflow) next_mode = MODE_PULL;
            else if (stop_enter) next_mode = MODE_STOP;
         end
         MODE_STOP:
         begin
            if (stop_wake || internal_reset) next_mode = MODE_RUN;
         end
         MODE_PULL:
         begin
            if (pull_done) next_mode = MODE_RUN;
         end
         default: next_mode = MODE_RUN;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         mode <= MODE_RUN;
         pull_count <= 5'h00;
      end
      else
      begin
         mode <= next_mode;
         if (mode != MODE_PULL)
            pull_count <= 5'h00;
         else if (ref_tick)
            pull_count <= pull_count + 5'h01;
      end
   end

   // Power-on count; runs once after reset release
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         por_count <= 13'h0000;
         por_done <= 1'b0;
      end
      else if (por_clear)
         por_done <= 1'b1;
      else if (ref_tick && !por_done)
         por_count <= por_count + 13'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clock)
   begin
      if (reset)
         cfg <= CFG_RESET;
      else if (cfg_write)
         cfg <= wdata;
   end

   // Set wins over the clear-on-read so no overflow is lost
   always_ff @(posedge clock)
   begin
      if (reset)
         cause_flag <= 1'b0;
      else if (overflow)
         cause_flag <= 1'b1;
      else if (cause_read)
         cause_flag <= 1'b0;
   end

   assign read_value =
      (addr == ADDR_SERVICE) ? RESET_VECTOR_LOW :
      (addr == ADDR_CONFIG) ? cfg :
      (addr == ADDR_CAUSE) ? 8'(cause_flag) << CAUSE_WATCHDOG_BIT :
      (addr == ADDR_COUNT) ? 8'(wd_count) : 8'h00;

   always_ff @(posedge clock)
   begin
      if (reset || !rd)
         rdata <= 8'h00;
      else
         rdata <= read_value;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; reset pin is open drain, only ever driven low
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         reset_pin_out <= 1'b0;
         reset_pin_oe <= 1'b0;
         watchdog_reset <= 1'b0;
         stop_mode <= 1'b0;
      end
      else
      begin
         reset_pin_out <= 1'b0;
         reset_pin_oe <= (next_mode == MODE_PULL);
         watchdog_reset <= (next_mode == MODE_PULL);
         stop_mode <= (next_mode == MODE_STOP);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   logic [7:0] low_ticks;

   always_ff @(posedge clock)
   begin
      if (reset || !reset_pin_oe)
         low_ticks <= 8'h00;
      else if (ref_tick)
         low_ticks <= low_ticks + 8'h01;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence s_overflow;
      overflow;
   endsequence

   sequence s_pull_start;
      reset_pin_oe && watchdog_reset && cause_flag && (wd_count == '0);
   endsequence

   property p_service_clears;
      svc_write && !overflow && mode != MODE_PULL |=>
         wd_count == '0 && prescaler[PRESCALER_W-1:SERVICE_CLEAR_LSB] == '0;
   endproperty
   a_service_clears: assert property (p_service_clears)
      else $error("service write did not clear the counter chain");

   property p_rate_reset;
      $past(reset) |-> !cfg[CFG_RATE_BIT];
   endproperty
   a_rate_reset: assert property (p_rate_reset)
      else $error("rate select not cleared by reset");

   property p_service_read;
      rd && addr == ADDR_SERVICE |=> rdata == RESET_VECTOR_LOW;
   endproperty
   a_service_read: assert property (p_service_read)
      else $error("service read returned wrong byte");

   property p_overflow_pull;
      s_overflow |=> s_pull_start;
   endproperty
   a_overflow_pull: assert property (p_overflow_pull)
      else $error("overflow did not pull the reset pin");

   property p_pull_length;
      $fell(reset_pin_oe) |-> low_ticks == 8'(PULL_CYCLES);
   endproperty
   a_pull_length: assert property (p_pull_length)
      else $error("reset pin low for wrong number of cycles");

   property p_disabled_quiet;
      !active |-> !overflow ##1 !$rose(reset_pin_oe);
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("disabled watchdog raised a reset");

   property p_stop_freeze;
      stop_mode && !internal_reset && !svc_write |=>
         $stable(wd_count) && prescaler == '0;
   endproperty
   a_stop_freeze: assert property (p_stop_freeze)
      else $error("counter moved in stop mode");

   property p_stop_gate;
      stop_request && !cfg[CFG_STOP_ALLOW_BIT] && !stop_mode |=> !stop_mode;
   endproperty
   a_stop_gate: assert property (p_stop_gate)
      else $error("stop entered without stop allow");

   property p_vector_fetch;
      vector_fetch |=> prescaler == '0;
   endproperty
   a_vector_fetch: assert property (p_vector_fetch)
      else $error("vector fetch did not clear prescaler");

   property p_internal_reset;
      internal_reset |=> chain == '0;
   endproperty
   a_internal_reset: assert property (p_internal_reset)
      else $error("internal reset did not clear the chain");

   // Clear sources other than the one a property watches
   sequence s_no_clear;
      !internal_reset && !svc_write && !stop_enter && !vector_fetch && !por_clear;
   endsequence

   property p_chain_step;
      (count_enable && !overflow) ##0 s_no_clear |=> chain == $past(chain) + 18'h00001;
   endproperty
   a_chain_step: assert property (p_chain_step)
      else $error("counter chain did not advance by one");

   property p_disabled_hold;
      (!active && mode == MODE_RUN) ##0 s_no_clear |=> $stable(chain);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold)
      else $error("disabled watchdog chain moved");

   property p_stop_entry;
      stop_enter && !overflow |=> prescaler == '0 && stop_mode;
   endproperty
   a_stop_entry: assert property (p_stop_entry)
      else $error("stop instruction did not clear the prescaler");

   property p_por_clear;
      por_clear |=> prescaler == '0;
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("power-on clear missed the prescaler");

endmodule // owd_watchdog

`default_nettype wire

//--- verif/owd_cpu_model.sv
// Processor core model: register cycles on demand, periodic servicing.
// Assumes the watchdog samples strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module owd_cpu_model
   import owd_pkg::*;
(
   input wire logic clock,
   input wire logic [DATA_W-1:0] rdata,
   output var logic [ADDR_W-1:0] addr,
   output var logic [DATA_W-1:0] wdata,
   output var logic wr,
   output var logic rd
);
   int service_gap = 0;

   task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      // Released bus shows no stale value
      addr <= ~a;
      wdata <= ~d;
   endtask

   task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      addr <= ~a;
      @(posedge clock);
      d = rdata;
   endtask

   initial
   begin
      addr = 16'h0000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      forever
      begin
         @(posedge clock);
         if (service_gap > 0)
         begin
            repeat (service_gap) @(posedge clock);
            bus_write(ADDR_SERVICE, 8'ha5);
         end
      end
   end
endmodule // owd_cpu_model

`default_nettype wire

//--- verif/owd_watchdog_bench.sv
// Self-checking bench for the operating watchdog, timeouts shortened.
// Assumes owd_cpu_model as the processor core on the register port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
begin \
   total_checks++; \
   if ((got) !== (exp)) \
   begin \
      err_count++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
   end \
end

module owd_watchdog_bench;
   import owd_pkg::*;
   localparam int T_LONG = 100;
   localparam int T_SHORT = 40;
   localparam logic [7:0] VEC_LOW = 8'h5a; // Arbitrary value
   logic clock;
   logic reset;
   logic [3:0] pulses;
   logic [3:0] gates;
   logic [7:0] q;
   wire logic [ADDR_W-1:0] addr;
   wire logic [DATA_W-1:0] wdata;
   wire logic [DATA_W-1:0] rdata;
   wire logic wr;
   wire logic rd;
   wire logic reset_pin_out;
   wire logic reset_pin_oe;
   wire logic watchdog_reset;
   wire logic stop_mode;
   int err_count;
   int total_checks;
   int cycles;
   int oe_seen;
   int n;

   owd_cpu_model owd_cpu_model_i (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   owd_watchdog #(.TIMEOUT_LONG_CYCLES(T_LONG), .TIMEOUT_SHORT_CYCLES(T_SHORT),
      .RESET_VECTOR_LOW(VEC_LOW)) owd_watchdog_i (
      .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .internal_reset(pulses[3]), .vector_fetch(pulses[2]),
      .stop_request(pulses[1]), .stop_wake(pulses[0]), .monitor_mode(gates[3]),
      .break_state(gates[2]), .test_voltage_reset_pin(gates[1]),
      .test_voltage_irq_pin(gates[0]), .reset_pin_out(reset_pin_out),
      .reset_pin_oe(reset_pin_oe), .watchdog_reset(watchdog_reset), .stop_mode(stop_mode));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic do_reset();
      @(posedge clock);
      reset <= 1'b1;
      repeat (20) @(posedge clock);
      reset <= 1'b0;
   endtask

   task automatic pulse(input int b);
      @(posedge clock);
      pulses[b] <= 1'b1;
      @(posedge clock);
      pulses[b] <= 1'b0;
   endtask

   task automatic quiet(input int c);
      repeat (c)
      begin
         @(posedge clock);
         oe_seen += int'(reset_pin_oe !== 1'b0);
      end
   endtask

   // Bounded so a dead timer cannot hang the run
   task automatic wait_oe();
      n = 0;
      while (reset_pin_oe !== 1'b1 && n < 5000)
      begin
         @(posedge clock);
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_overflow();
      int w = 0;
      int mis = 0;
      wait_oe();
      `CHK(n inside {[T_LONG-3:T_LONG+3]}, 1'b1)
      while (reset_pin_oe === 1'b1 && w < 100)
      begin
         mis += int'(watchdog_reset !== 1'b1 || reset_pin_out !== 1'b0);
         w++;
         @(posedge clock);
      end
      `CHK(w, 32)
      `CHK(mis, 0)
      owd_cpu_model_i.bus_read(ADDR_CAUSE, q);
      `CHK(q[CAUSE_WATCHDOG_BIT], 1'b1)
      $display("test overflow done");
   endtask

   task automatic t_regs_service();
      do_reset();
      owd_cpu_model_i.bus_read(ADDR_CONFIG, q);
      `CHK(q, CFG_RESET)
      owd_cpu_model_i.bus_read(ADDR_SERVICE, q);
      `CHK(q, VEC_LOW)
      owd_cpu_model_i.bus_read(16'h0100, q);
      `CHK(q, 8'h00)
      owd_cpu_model_i.bus_write(ADDR_CONFIG, 8'h04);
      owd_cpu_model_i.bus_read(ADDR_CONFIG, q);
      `CHK(q, 8'h04)
      owd_cpu_model_i.service_gap = 12;
      oe_seen = 0;
      quiet(300);
      `CHK(oe_seen, 0)
      owd_cpu_model_i.service_gap = 0;
      // Long enough for the model's last service, short of a short timeout
      repeat (15) @(posedge clock);
      owd_cpu_model_i.bus_write(ADDR_SERVICE, 8'h00);
      wait_oe();
      `CHK(n inside {[T_SHORT-18:T_SHORT+2]}, 1'b1)
      $display("test registers and service done");
   endtask

   task automatic t_gate();
      // Columns: disable bit, monitor, break, voltage on reset pin, on irq pin
      logic [4:0] cases [5] = '{5'h10, 5'h0a, 5'h09, 5'h06, 5'h05};
      for (int i = 0; i < 5; i++)
      begin
         do_reset();
         owd_cpu_model_i.bus_write(ADDR_CONFIG, {7'h00, cases[i][4]});
         gates <= cases[i][3:0];
         oe_seen = 0;
         quiet(250);
         `CHK(oe_seen == 0, i < 4)
         gates <= 4'h0;
      end
      $display("test gating done");
   endtask

   task automatic t_stop();
      do_reset();
      pulse(1);
      repeat (2) @(posedge clock);
      `CHK(stop_mode, 1'b0)
      owd_cpu_model_i.bus_write(ADDR_CONFIG, 8'h02);
      pulse(1);
      oe_seen = 0;
      quiet(300);
      `CHK(stop_mode, 1'b1)
      `CHK(oe_seen, 0)
      pulse(0);
      wait_oe();
      `CHK(stop_mode, 1'b0)
      `CHK(n inside {[T_LONG-3:T_LONG+3]}, 1'b1)
      $display("test stop done");
   endtask

   task automatic t_clears();
      for (int b = 2; b < 4; b++)
      begin
         do_reset();
         oe_seen = 0;
         repeat (6)
         begin
            quiet(60);
            pulse(b);
         end
         `CHK(oe_seen, 0)
      end
      $display("test clears done");
   endtask

   // Frozen chain keeps its count; in this test only the power-on clear empties it
   task automatic t_power_on();
      do_reset();
      quiet(60);
      owd_cpu_model_i.bus_write(ADDR_CONFIG, 8'h01);
      oe_seen = 0;
      quiet(4100);
      `CHK(oe_seen, 0)
      owd_cpu_model_i.bus_write(ADDR_CONFIG, 8'h00);
      wait_oe();
      `CHK(n inside {[T_LONG-3:T_LONG+3]}, 1'b1)
      $display("test power-on clear done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial
   begin
      reset = 1'b1;
      pulses = 4'h0;
      gates = 4'h0;
      err_count = 0;
      total_checks = 0;
      cycles = 0;
      do_reset();
      t_overflow();
      t_regs_service();
      t_gate();
      t_stop();
      t_clears();
      t_power_on();
      results();
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         err_count++;
         results();
      end
   end
endmodule // owd_watchdog_bench

`default_nettype wire
